// file: hw/sbst_consts.svh
/*
   constants of the sram boundary-scan test port: instruction codes,
   scan register sizes, special cell positions and capture patterns.
   assumes it is included by bare name from the design files.
*/
// Operation
// - tdo changes only on falling tck edges
// - lsb drives tdo, tdi enters msb
// - tdi sampled on rising tck while shifting
// - port reset never disturbs memory operation
// - power-up reset leaves tdo high impedance
// - exactly one register between tdi and tdo
// - three-bit instruction register, serially loaded
// - reset state loads identification instruction
// - capture-ir loads 01 into low bits
// - new instruction acts only after update-ir
// - bypass is one bit, captured low
// - bypass instruction selects bypass bit in shift-dr
// - boundary chain captures pin ring, shifts in shift-dr
// - id instruction captures hardwired 32-bit code
// - sample-z selects chain, forces output bus high-z
// - sample/preload snapshots pins without affecting memory
// - preload shifts in, update-dr latches it
// - extest drives latched values onto pins
// - cell 108 high enables bus, low high-z
// - tristate cell latches only in update-dr
// - tristate latch preset low at reset
// - extest 000, idcode 001, sample-z 010
// - sample 100, bypass 111, others reserved
`ifndef SBST_CONSTS_SVH
`define SBST_CONSTS_SVH

// instruction register
`define SBST_IR_WIDTH 3
`define SBST_IR_EXTEST 3'h0
`define SBST_IR_IDCODE 3'h1
`define SBST_IR_SAMPLEZ 3'h2
`define SBST_IR_SAMPLE 3'h4
`define SBST_IR_BYPASS 3'h7
// capture-ir pattern, low two bits 01
`define SBST_IR_CAPTURE 3'h1

// scan register sizes
`define SBST_ID_WIDTH 32
`define SBST_BSR_WIDTH 109
// output bus tristate cell
`define SBST_TRI_CELL 108
// reset value of the preload latches
`define SBST_LATCH_RESET 109'h0

`endif

// file: hw/sbst_pkg.sv
/*
   types of the sram boundary-scan test port: tap states, scan path
   selection and the pin control bundle.
   assumes nothing beyond a systemverilog compiler.
*/
package sbst_pkg;

   // sixteen tap controller states
   typedef enum logic [3:0] {
      TLR, RTI, SEL_DR, CAP_DR, SHF_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
      SEL_IR, CAP_IR, SHF_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
   } sbst_state_t;

   // data register in the scan path
   typedef enum logic [1:0] {
      SEL_BYPASS, SEL_ID, SEL_BSR
   } sbst_sel_t;

   // control toward the memory pin drivers
   typedef struct packed {
      logic extest;   // drive latched values on the pins
      logic qbus_hiz; // force read-data bus high impedance
   } sbst_pin_ctrl_t;

endpackage : sbst_pkg

// file: hw/sbst_sync.sv
/*
   two flip-flop synchroniser for a bundle of pin inputs.
   assumes the inputs are quasi-static relative to clock_in.
*/
`timescale 1ns/1ps
`default_nettype none
module sbst_sync #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input wire logic clock_in,
   input wire logic rst_in,
   // asynchronous side
   input wire logic [WIDTH-1:0] async_in,
   // synchronised side
   output logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_reg; // first stage, read only by second stage

   // two stages, cleared by reset
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         meta_reg <= '0;
         sync_out <= '0;
      end else begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end

endmodule : sbst_sync
`default_nettype wire

// file: hw/sbst_tap_fsm.sv
/*
   tap controller state machine, advanced once per rising test clock.
   assumes step_in is a one-cycle pulse at each tck rise and tms_in is
   already synchronised to clock_in.
*/
`timescale 1ns/1ps
`default_nettype none
module sbst_tap_fsm (
   // clock and reset
   input wire logic clock_in,
   input wire logic rst_in,
   // test clock rise and mode select
   input wire logic step_in,
   input wire logic tms_in,
   // current state
   output sbst_pkg::sbst_state_t state_out
);

   sbst_pkg::sbst_state_t state_next; // next state

   // next state from mode select
   always_comb begin
      state_next = state_out;
      case (state_out)
         sbst_pkg::TLR: state_next = tms_in ? sbst_pkg::TLR : sbst_pkg::RTI;
         sbst_pkg::RTI: state_next = tms_in ? sbst_pkg::SEL_DR : sbst_pkg::RTI;
         sbst_pkg::SEL_DR: state_next = tms_in ? sbst_pkg::SEL_IR : sbst_pkg::CAP_DR;
         sbst_pkg::CAP_DR: state_next = tms_in ? sbst_pkg::EX1_DR : sbst_pkg::SHF_DR;
         sbst_pkg::SHF_DR: state_next = tms_in ? sbst_pkg::EX1_DR : sbst_pkg::SHF_DR;
         sbst_pkg::EX1_DR: state_next = tms_in ? sbst_pkg::UPD_DR : sbst_pkg::PAU_DR;
         sbst_pkg::PAU_DR: state_next = tms_in ? sbst_pkg::EX2_DR : sbst_pkg::PAU_DR;
         sbst_pkg::EX2_DR: state_next = tms_in ? sbst_pkg::UPD_DR : sbst_pkg::SHF_DR;
         sbst_pkg::UPD_DR: state_next = tms_in ? sbst_pkg::SEL_DR : sbst_pkg::RTI;
         sbst_pkg::SEL_IR: state_next = tms_in ? sbst_pkg::TLR : sbst_pkg::CAP_IR;
         sbst_pkg::CAP_IR: state_next = tms_in ? sbst_pkg::EX1_IR : sbst_pkg::SHF_IR;
         sbst_pkg::SHF_IR: state_next = tms_in ? sbst_pkg::EX1_IR : sbst_pkg::SHF_IR;
         sbst_pkg::EX1_IR: state_next = tms_in ? sbst_pkg::UPD_IR : sbst_pkg::PAU_IR;
         sbst_pkg::PAU_IR: state_next = tms_in ? sbst_pkg::EX2_IR : sbst_pkg::PAU_IR;
         sbst_pkg::EX2_IR: state_next = tms_in ? sbst_pkg::UPD_IR : sbst_pkg::SHF_IR;
         sbst_pkg::UPD_IR: state_next = tms_in ? sbst_pkg::SEL_DR : sbst_pkg::RTI;
         default: state_next = sbst_pkg::TLR;
      endcase
   end

   // state advances only at test clock rise; five tms highs reach tlr
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         state_out <= sbst_pkg::TLR;
      end else if (step_in) begin
         state_out <= state_next;
      end
   end

endmodule : sbst_tap_fsm
`default_nettype wire

// file: hw/sbst_tap.sv
/*
   boundary-scan test access port of a synchronous sram: tck edge
   detection, instruction, bypass, id and boundary registers, tdo
   driver and the pin control for extest and sample-z.
   assumes tck, tms, tdi and the pin ring arrive asynchronously and
   that tck is well below a quarter of clock_in. rst_in is power-up.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sbst_consts.svh"
module sbst_tap #(
   parameter int BSR_WIDTH = `SBST_BSR_WIDTH,
   // arbitrary identification value, bit 0 must stay 1
   parameter logic [`SBST_ID_WIDTH-1:0] ID_CODE = 32'h0000_0001
) (
   // clock and reset
   input wire logic clock_in,
   input wire logic rst_in,
   // test port pins
   input wire logic tck_in,
   input wire logic tms_in,
   input wire logic tdi_in,
   output logic tdo_out,
   output logic tdo_oe_out,
   // memory pin ring
   input wire logic [BSR_WIDTH-1:0] ring_in,
   output logic [BSR_WIDTH-1:0] ring_drive_out,
   output sbst_pkg::sbst_pin_ctrl_t pin_ctrl_out
);

   logic tck_s; // synchronised test clock
   logic tms_s; // synchronised mode select
   logic tdi_s; // synchronised data in
   logic [BSR_WIDTH-1:0] ring_s; // synchronised pin ring
   logic tck_prev_reg; // test clock one cycle ago
   logic tck_rise; // one-cycle pulse at tck rise
   logic tck_fall; // one-cycle pulse at tck fall
   sbst_pkg::sbst_state_t state; // tap state
   logic [`SBST_IR_WIDTH-1:0] ir_reg; // active instruction
   logic [`SBST_IR_WIDTH-1:0] ir_sr_reg; // instruction shift stage
   logic byp_reg; // bypass bit
   logic [`SBST_ID_WIDTH-1:0] id_sr_reg; // id shift register
   logic [BSR_WIDTH-1:0] bsr_reg; // boundary shift register
   logic [BSR_WIDTH-1:0] latch_reg; // boundary preload latches
   sbst_pkg::sbst_sel_t sel; // data register in the path
   logic dr_lsb; // lsb of the selected data register

   // all pin inputs through two flip-flops
   sbst_sync #(
      .WIDTH(BSR_WIDTH + 3)
   ) u_sync (
      .clock_in(clock_in),
      .rst_in(rst_in),
      .async_in({tck_in, tms_in, tdi_in, ring_in}),
      .sync_out({tck_s, tms_s, tdi_s, ring_s})
   );

   // test clock edge detection
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         tck_prev_reg <= 1'b0;
      end else begin
         tck_prev_reg <= tck_s;
      end
   end
   assign tck_rise = tck_s & ~tck_prev_reg;
   assign tck_fall = ~tck_s & tck_prev_reg;

   // tap controller
   sbst_tap_fsm u_fsm (
      .clock_in(clock_in),
      .rst_in(rst_in),
      .step_in(tck_rise),
      .tms_in(tms_s),
      .state_out(state)
   );

   // data register chosen by the instruction; reserved codes bypass
   always_comb begin
      case (ir_reg)
         `SBST_IR_EXTEST: sel = sbst_pkg::SEL_BSR;
         `SBST_IR_SAMPLEZ: sel = sbst_pkg::SEL_BSR;
         `SBST_IR_SAMPLE: sel = sbst_pkg::SEL_BSR;
         `SBST_IR_IDCODE: sel = sbst_pkg::SEL_ID;
         default: sel = sbst_pkg::SEL_BYPASS;
      endcase
   end

   // lsb of the selected data register, one at a time
   always_comb begin
      case (sel)
         sbst_pkg::SEL_BSR: dr_lsb = bsr_reg[0];
         sbst_pkg::SEL_ID: dr_lsb = id_sr_reg[0];
         default: dr_lsb = byp_reg;
      endcase
   end

   // instruction shift stage: capture 01, shift lsb first
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         ir_sr_reg <= `SBST_IR_CAPTURE;
      end else if (tck_rise && state == sbst_pkg::CAP_IR) begin
         ir_sr_reg <= `SBST_IR_CAPTURE;
      end else if (tck_rise && state == sbst_pkg::SHF_IR) begin
         ir_sr_reg <= {tdi_s, ir_sr_reg[`SBST_IR_WIDTH-1:1]};
      end
   end

   // active instruction: idcode in reset, new code only at update-ir
   always_ff @(posedge clock_in) begin
      if (rst_in || state == sbst_pkg::TLR) begin
         ir_reg <= `SBST_IR_IDCODE;
      end else if (tck_rise && state == sbst_pkg::UPD_IR) begin
         ir_reg <= ir_sr_reg;
      end
   end

   // bypass bit: captured low, shifted from tdi
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         byp_reg <= 1'b0;
      end else if (tck_rise && sel == sbst_pkg::SEL_BYPASS) begin
         if (state == sbst_pkg::CAP_DR) begin
            byp_reg <= 1'b0;
         end else if (state == sbst_pkg::SHF_DR) begin
            byp_reg <= tdi_s;
         end
      end
   end

   // id register: hardwired capture, shift toward tdo
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         id_sr_reg <= ID_CODE;
      end else if (tck_rise && sel == sbst_pkg::SEL_ID) begin
         if (state == sbst_pkg::CAP_DR) begin
            id_sr_reg <= ID_CODE;
         end else if (state == sbst_pkg::SHF_DR) begin
            id_sr_reg <= {tdi_s, id_sr_reg[`SBST_ID_WIDTH-1:1]};
         end
      end
   end

   // boundary chain: capture the ring, shift msb in, lsb out
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         bsr_reg <= '0;
      end else if (tck_rise && sel == sbst_pkg::SEL_BSR) begin
         if (state == sbst_pkg::CAP_DR) begin
            bsr_reg <= ring_s;
         end else if (state == sbst_pkg::SHF_DR) begin
            bsr_reg <= {tdi_s, bsr_reg[BSR_WIDTH-1:1]};
         end
      end
   end

   // preload latches: only update-dr under sample/preload or extest
   always_ff @(posedge clock_in) begin
      if (rst_in || state == sbst_pkg::TLR) begin
         latch_reg <= `SBST_LATCH_RESET;
      end else if (tck_rise && state == sbst_pkg::UPD_DR &&
                   (ir_reg == `SBST_IR_SAMPLE || ir_reg == `SBST_IR_EXTEST)) begin
         latch_reg <= bsr_reg;
      end
   end

   // serial output on the falling test clock, enabled while shifting
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         tdo_out <= 1'b0;
         tdo_oe_out <= 1'b0;
      end else if (tck_fall) begin
         tdo_oe_out <= (state == sbst_pkg::SHF_IR) || (state == sbst_pkg::SHF_DR);
         tdo_out <= (state == sbst_pkg::SHF_IR) ? ir_sr_reg[0] : dr_lsb;
      end
   end

   // pin control; memory path is never touched outside extest/sample-z
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         pin_ctrl_out <= '0;
         ring_drive_out <= '0;
      end else begin
         pin_ctrl_out.extest <= (ir_reg == `SBST_IR_EXTEST);
         pin_ctrl_out.qbus_hiz <= (ir_reg == `SBST_IR_SAMPLEZ) ||
            ((ir_reg == `SBST_IR_EXTEST) && !latch_reg[`SBST_TRI_CELL]);
         ring_drive_out <= latch_reg;
      end
   end

   // steps of the serial protocol
   sequence s_upd_ir;
      tck_rise && state == sbst_pkg::UPD_IR;
   endsequence

   sequence s_cap_dr_sel(sbst_pkg::sbst_sel_t s);
      tck_rise && state == sbst_pkg::CAP_DR && sel == s;
   endsequence

   sequence s_shf_bsr;
      tck_rise && state == sbst_pkg::SHF_DR && sel == sbst_pkg::SEL_BSR;
   endsequence

   AST_TDO_FALL_ONLY: assert property (@(posedge clock_in) disable iff (rst_in)
      $changed(tdo_out) |-> $past(tck_fall))
      else $error("tdo changed without a tck fall");

   AST_TDO_HIZ_RESET: assert property (@(posedge clock_in)
      rst_in |=> !tdo_oe_out)
      else $error("tdo enabled after reset");

   AST_TLR_IDCODE: assert property (@(posedge clock_in) disable iff (rst_in)
      state == sbst_pkg::TLR |=> ir_reg == `SBST_IR_IDCODE)
      else $error("reset state did not load idcode");

   AST_CAP_IR: assert property (@(posedge clock_in) disable iff (rst_in)
      tck_rise && state == sbst_pkg::CAP_IR |=> ir_sr_reg[1:0] == 2'h1)
      else $error("capture-ir pattern wrong");

   AST_UPD_IR: assert property (@(posedge clock_in) disable iff (rst_in)
      s_upd_ir |=> ir_reg == $past(ir_sr_reg))
      else $error("update-ir did not load instruction");

   AST_IR_HOLD: assert property (@(posedge clock_in) disable iff (rst_in)
      (state != sbst_pkg::TLR && !(tck_rise && state == sbst_pkg::UPD_IR))
      |=> $stable(ir_reg))
      else $error("instruction changed outside update-ir");

   AST_BYP_CAP: assert property (@(posedge clock_in) disable iff (rst_in)
      s_cap_dr_sel(sbst_pkg::SEL_BYPASS) |=> !byp_reg)
      else $error("bypass not captured low");

   AST_ID_CAP: assert property (@(posedge clock_in) disable iff (rst_in)
      s_cap_dr_sel(sbst_pkg::SEL_ID) |=> id_sr_reg == ID_CODE)
      else $error("id code not captured");

   AST_BSR_SHIFT: assert property (@(posedge clock_in) disable iff (rst_in)
      s_shf_bsr |=> bsr_reg[BSR_WIDTH-1] == $past(tdi_s) &&
                    bsr_reg[BSR_WIDTH-2:0] == $past(bsr_reg[BSR_WIDTH-1:1]))
      else $error("boundary chain shift wrong");

   AST_SAMPLEZ_HIZ: assert property (@(posedge clock_in) disable iff (rst_in)
      ir_reg == `SBST_IR_SAMPLEZ [*2] |-> pin_ctrl_out.qbus_hiz)
      else $error("sample-z left output bus driven");

   AST_EXTEST_TRI: assert property (@(posedge clock_in) disable iff (rst_in)
      ir_reg == `SBST_IR_EXTEST |=>
      pin_ctrl_out.qbus_hiz == !$past(latch_reg[`SBST_TRI_CELL]))
      else $error("tristate cell does not steer bus");

   AST_LATCH_HOLD: assert property (@(posedge clock_in) disable iff (rst_in)
      (state != sbst_pkg::TLR && !(tck_rise && state == sbst_pkg::UPD_DR))
      |=> $stable(latch_reg))
      else $error("preload latch changed outside update-dr");

   AST_TLR_LATCH: assert property (@(posedge clock_in) disable iff (rst_in)
      state == sbst_pkg::TLR |=> !latch_reg[`SBST_TRI_CELL])
      else $error("tristate latch not preset low");

endmodule : sbst_tap
`default_nettype wire

// file: bench/sbst_jtag_model.sv
/*
   behavioural boundary-scan test controller driving the tap pins.
   assumes clock_in is the 50 MHz system clock; tck runs at 160 ns.
*/
`timescale 1ns/1ps
`default_nettype none
module sbst_jtag_model (
   // pacing clock
   input wire logic clock_in,
   // test port toward the device
   output logic tck_out,
   output logic tms_out,
   output logic tdi_out,
   input wire logic tdo_in
);
   // idle: tck stands low, tms and tdi at pull-up level
   initial begin
      tck_out = 1'b0;
      tms_out = 1'b1;
      tdi_out = 1'b1;
   end

   // half tck period, four system clocks
   task automatic half;
      repeat (4) @(posedge clock_in);
      #1;
   endtask : half

   // one tck period: fall, set tms and tdi, rise, sample tdo before next fall
   task automatic step(input logic tms, input logic tdi, output logic tdo);
      tck_out = 1'b0;
      tms_out = tms;
      tdi_out = tdi;
      half();
      tck_out = 1'b1;
      half();
      tdo = tdo_in;
   endtask : step

   // park tck low between frames
   task automatic park;
      tck_out = 1'b0;
      tms_out = 1'b1;
      tdi_out = 1'b1;
      half();
   endtask : park

   // five rises with tms high, then one to idle
   task automatic tap_reset;
      logic unused;
      for (int i = 0; i < 5; i++) begin
         step(1'b1, 1'b1, unused);
      end
      step(1'b0, 1'b1, unused);
      park();
   endtask : tap_reset
endmodule : sbst_jtag_model
`default_nettype wire

// file: bench/sbst_tap_tb.sv
/*
   self-checking bench of the boundary-scan tap: scans through the
   controller model and checks the pin control outputs.
   assumes the design's default 109-cell boundary chain.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sbst_consts.svh"
module sbst_tap_tb;
   // arbitrary identification value, bit 0 set
   localparam logic [31:0] TB_ID = 32'h5a5a_c3c3;
   localparam logic [108:0] PAT = {1'b1, {9{12'h5c3}}}; // ring pattern
   localparam logic [108:0] LD1 = {1'b1, {27{4'h9}}}; // preload, bus on
   localparam logic [108:0] LD2 = {1'b0, {27{4'h6}}}; // preload, bus off
   logic clock_in = 1'b0;
   logic rst_in = 1'b1;
   logic tck, tms, tdi, tdo_out, tdo_oe_out;
   logic tdo_pin; // tdo as the controller sees it
   // released tdo has no pull, so show the inverse to expose late sampling
   assign tdo_pin = tdo_oe_out ? tdo_out : ~tdo_out;
   logic [108:0] ring_in = 109'h0;
   logic [108:0] ring_drive_out;
   sbst_pkg::sbst_pin_ctrl_t pin_ctrl_out;
   int err_count = 0;
   int cmp_count = 0;
   int cycles = 0;

   // 50 MHz system clock
   always #10 clock_in = ~clock_in;

   sbst_tap #(.ID_CODE(TB_ID)) i_sbst_tap (
      .clock_in(clock_in), .rst_in(rst_in), .tck_in(tck), .tms_in(tms),
      .tdi_in(tdi), .tdo_out(tdo_out), .tdo_oe_out(tdo_oe_out),
      .ring_in(ring_in), .ring_drive_out(ring_drive_out), .pin_ctrl_out(pin_ctrl_out)
   );
   sbst_jtag_model i_sbst_jtag_model (
      .clock_in(clock_in), .tck_out(tck), .tms_out(tms), .tdi_out(tdi), .tdo_in(tdo_pin)
   );

   // verdict and end of run
   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : end_of_test

   // hang guard
   always @(posedge clock_in) begin
      cycles++;
      if (cycles == 40000) begin
         err_count++;
         end_of_test();
      end
   end

   // compare one vector result
   task automatic chk(input string name, input logic [108:0] exp, input logic [108:0] got);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   // pin control fields against expectation
   task automatic chk_pins(input logic ext, input logic hiz);
      chk("extest", 109'(ext), 109'(pin_ctrl_out.extest));
      chk("qbus_hiz", 109'(hiz), 109'(pin_ctrl_out.qbus_hiz));
   endtask : chk_pins

   // instruction scan from idle, back to idle
   task automatic ir_scan(input logic [2:0] code);
      logic [2:0] got;
      logic d;
      i_sbst_jtag_model.step(1'b1, 1'b1, d);
      i_sbst_jtag_model.step(1'b1, 1'b1, d);
      i_sbst_jtag_model.step(1'b0, 1'b1, d);
      i_sbst_jtag_model.step(1'b0, 1'b1, d);
      for (int i = 0; i < 3; i++) begin
         i_sbst_jtag_model.step(i == 2, code[i], got[i]);
      end
      chk("ir capture", 109'h1, 109'(got));
      i_sbst_jtag_model.step(1'b1, 1'b1, d);
      i_sbst_jtag_model.step(1'b0, 1'b1, d);
      i_sbst_jtag_model.park();
   endtask : ir_scan

   // data scan of n bits from idle, back to idle
   task automatic dr_scan(input int n, input logic [108:0] din, output logic [108:0] dout);
      logic d;
      dout = 109'h0;
      i_sbst_jtag_model.step(1'b1, 1'b1, d);
      i_sbst_jtag_model.step(1'b0, 1'b1, d);
      i_sbst_jtag_model.step(1'b0, 1'b1, d);
      for (int i = 0; i < n; i++) begin
         i_sbst_jtag_model.step(i == n - 1, din[i], dout[i]);
         if (i == 0) begin
            chk("tdo_oe shift", 109'h1, 109'(tdo_oe_out));
         end
      end
      i_sbst_jtag_model.step(1'b1, 1'b1, d);
      i_sbst_jtag_model.step(1'b0, 1'b1, d);
      i_sbst_jtag_model.park();
      chk("tdo_oe idle", 109'h0, 109'(tdo_oe_out));
   endtask : dr_scan

   // power-up state and identification read
   task automatic t_power_up;
      logic [108:0] r;
      chk("tdo_oe reset", 109'h0, 109'(tdo_oe_out));
      chk("drive reset", 109'h0, ring_drive_out);
      chk_pins(1'b0, 1'b0);
      dr_scan(32, {109{1'b1}}, r);
      chk("id code", 109'(TB_ID), r);
      $display("test power_up done");
   endtask : t_power_up

   // bypass gives one low stage
   task automatic t_bypass;
      logic [108:0] r;
      ir_scan(`SBST_IR_BYPASS);
      dr_scan(8, 109'hb5, r);
      chk("bypass out", 109'h6a, r);
      chk_pins(1'b0, 1'b0);
      $display("test bypass done");
   endtask : t_bypass

   // sample snapshot, preload shifted in and latched
   task automatic t_preload;
      logic [108:0] r;
      ir_scan(`SBST_IR_SAMPLE);
      dr_scan(109, LD1, r);
      chk("sample capture", PAT, r);
      chk("preload latch", LD1, ring_drive_out);
      chk_pins(1'b0, 1'b0);
      $display("test preload done");
   endtask : t_preload

   // extest drives latches, cell 108 gates the bus
   task automatic t_extest;
      logic [108:0] r;
      ir_scan(`SBST_IR_EXTEST);
      chk_pins(1'b1, 1'b0);
      dr_scan(109, LD2, r);
      chk("extest capture", PAT, r);
      chk("extest latch", LD2, ring_drive_out);
      chk_pins(1'b1, 1'b1);
      $display("test extest done");
   endtask : t_extest

   // sample-z forces the bus off, latches untouched
   task automatic t_samplez;
      logic [108:0] r;
      ir_scan(`SBST_IR_SAMPLEZ);
      chk_pins(1'b0, 1'b1);
      dr_scan(109, LD1, r);
      chk("samplez capture", PAT, r);
      chk("samplez latch", LD2, ring_drive_out);
      $display("test samplez done");
   endtask : t_samplez

   // five tms highs restore identification and clear latches
   task automatic t_tap_reset;
      logic [108:0] r;
      logic d;
      // park in shift-dr, one of the states farthest from reset, so all five rises count
      i_sbst_jtag_model.step(1'b1, 1'b1, d);
      i_sbst_jtag_model.step(1'b0, 1'b1, d);
      i_sbst_jtag_model.step(1'b0, 1'b1, d);
      i_sbst_jtag_model.tap_reset();
      chk("drive after tlr", 109'h0, ring_drive_out);
      chk_pins(1'b0, 1'b0);
      dr_scan(32, 109'h0, r);
      chk("id after tlr", 109'(TB_ID), r);
      $display("test tap_reset done");
   endtask : t_tap_reset

   // main sequence; only implemented codes are loaded
   initial begin
      logic d;
      repeat (8) @(posedge clock_in);
      #1;
      rst_in = 1'b0;
      ring_in = PAT;
      repeat (4) @(posedge clock_in);
      #1;
      i_sbst_jtag_model.step(1'b0, 1'b1, d);
      i_sbst_jtag_model.park();
      t_power_up();
      t_bypass();
      t_preload();
      t_extest();
      t_samplez();
      t_tap_reset();
      end_of_test();
   end
endmodule : sbst_tap_tb
`default_nettype wire
